// >>> rtl/field_threshold_regulator_regs.sv
/*
 * apb register bank for field detector off thresholds, driver timing
 * readout and regulator voltage control of a contactless front end.
 * assumes apb with 32-bit data, inputs synchronous to clk_sys, and
 * analogue blocks that consume the registered control outputs.
 */
// Overview of operation
// - off threshold register, rw, bit7 zero
// - bits 6:4 peer code, reset 011
// - bits 3:0 collision code, reset 0011
// - read-only driver timing register, bit3 reserved
// - bits 7:4 report transient ratio count
// - bits 2:0 report driver speed class
// - regulator control register rw, reset zero
// - bit7 picks adjust result or host code
// - bits 6:3 host code, 5v fixes 3.4v
// - bits 2:0 select measured supply
// - regulator display: adjust code, current limit
`timescale 1ns/10ps
module field_threshold_regulator_regs #(
  parameter int ADDR_W = 12
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analogue status
  input wire logic supply_5v_mode,
  input wire logic [3:0] adj_result,
  input wire logic rf_current_limit,
  input wire logic [3:0] transient_ratio,
  input wire logic [2:0] drive_speed,
  // field detector controls
  output logic [2:0] peer_thresh_code,
  output logic [3:0] coll_thresh_code,
  output logic coll_low_range,
  output logic [fthr_pkg::MV_W-1:0] peer_thresh_mv,
  output logic [fthr_pkg::MV_W-1:0] coll_thresh_mv,
  // regulator controls
  output logic reg_from_host,
  output logic [3:0] reg_rf_code,
  output logic [3:0] reg_dig_ana_code,
  output logic dig_ana_at_3v4,
  output logic [2:0] supply_meas_sel,
  output logic supply_meas_valid,
  // driver timing decode
  output logic drive_is_fast
);
  import fthr_pkg::*;

  // ==========================================================
  // register storage
  // ==========================================================
  logic [7:0] field_off_threshold_r;
  logic [7:0] regulator_voltage_control_r;
  logic [6:0] drv_sample;
  logic [4:0] reg_sample;
  apb_state_t apb_state_r;
  apb_state_t apb_state_nxt;
  logic [31:0] prdata_r;
  logic pslverr_r;
  // registered copies of every control, so each output is a flop
  logic [2:0] peer_code_r;
  logic [3:0] coll_code_r;
  logic coll_low_r;
  logic host_sel_r;
  logic [3:0] rf_code_r;
  logic [3:0] dig_ana_code_r;
  logic at_3v4_r;
  logic [2:0] meas_sel_r;
  logic meas_valid_r;
  logic fast_r;

  // ==========================================================
  // readout sampling
  // ==========================================================
  // status words are sampled every enabled cycle, so a read shows
  // the value from one cycle before the setup edge
  // ratio and speed captured
  readout_sample #(
    .W(7)
  ) u_drv_sample (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .d({transient_ratio, drive_speed}),
    .q_r(drv_sample)
  );

  readout_sample #(
    .W(5)
  ) u_reg_sample (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .d({adj_result, rf_current_limit}),
    .q_r(reg_sample)
  );

  // ==========================================================
  // address decode
  // ==========================================================
  // word index; a byte offset inside a word is refused, not rounded
  wire [ADDR_W-3:0] idx = paddr[ADDR_W-1:2];
  wire aligned = (paddr[1:0] == 2'h0);
  // readouts live in space b, at space a indexes plus a base
  // space b shares indexes with space a, so one flat map needs
  // an offset; the base is a package constant and can move
  wire [ADDR_W-3:0] idx_b_drv =
    (ADDR_W-2)'(SPACE_B_BASE) + (ADDR_W-2)'(IDX_DRIVER_TIMING_READOUT);
  wire [ADDR_W-3:0] idx_b_disp =
    (ADDR_W-2)'(SPACE_B_BASE) + (ADDR_W-2)'(IDX_REGULATOR_DISPLAY);
  wire hit_off = aligned && idx == (ADDR_W-2)'(IDX_FIELD_OFF_THRESHOLD);
  wire hit_ctrl =
    aligned && idx == (ADDR_W-2)'(IDX_REGULATOR_VOLTAGE_CONTROL);
  wire hit_drv = aligned && idx == idx_b_drv;
  wire hit_disp = aligned && idx == idx_b_disp;
  // anything outside the four words ends in an error response
  wire hit_any = hit_off | hit_ctrl | hit_drv | hit_disp;

  // ==========================================================
  // apb handshake
  // ==========================================================
  // setup phase seen while no answer is pending
  wire setup_phase = psel && !penable && apb_state_r == APB_IDLE;
  // transfer completes on the edge where pready is high
  wire xfer_done = psel && penable && apb_state_r == APB_ANSWER;
  // write lands only on the completing edge, low byte lane enabled
  wire wr_en = xfer_done && pwrite && pstrb[0] && !pslverr_r;
  wire wr_off = wr_en && hit_off;
  wire wr_ctrl = wr_en && hit_ctrl;

  // one access cycle per transfer while ce is high; ce low at the setup edge
  // leaves the bank idle, and the master then waits for a pready that never rises
  // state walk: idle -> answer on setup, answer -> idle on done
  always_comb begin
    apb_state_nxt = apb_state_r;
    unique case (apb_state_r)
      APB_IDLE: begin
        if (setup_phase) begin
          apb_state_nxt = APB_ANSWER;
        end
      end
      APB_ANSWER: begin
        if (xfer_done || !psel) begin
          apb_state_nxt = APB_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      apb_state_r <= APB_IDLE;
    end else if (ce) begin
      apb_state_r <= apb_state_nxt;
    end
  end

  // ==========================================================
  // read data assembly
  // ==========================================================
  // reserved bit 3 returns zero
  wire [7:0] drv_word = {drv_sample[6:3], 1'b0, drv_sample[2:0]};
  // adjust code high, limit flag bit 0
  wire [7:0] disp_word = {reg_sample[4:1], 3'h0, reg_sample[0]};
  wire [7:0] off_word = {1'b0, field_off_threshold_r[6:0]};
  wire [7:0] rd_byte =
    hit_off ? off_word :
    hit_ctrl ? regulator_voltage_control_r :
    hit_drv ? drv_word :
    hit_disp ? disp_word : 8'h00;

  // answer prepared in setup, held through access
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (ce && setup_phase) begin
      prdata_r <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      pslverr_r <= !hit_any;
    end else if (ce && apb_state_r == APB_ANSWER) begin
      // clearing on every answer also covers a master that drops psel
      // early, so stale read data never lingers on the bus
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
  end

  // answer outputs come straight from their flops
  assign prdata = prdata_r;
  assign pready = (apb_state_r == APB_ANSWER);
  assign pslverr = pslverr_r;

  // ==========================================================
  // threshold register
  // ==========================================================
  // rw register, bit 7 held zero
  // collision code reset 0011
  // bit 7 is forced to zero on write, so it never reads back one
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      field_off_threshold_r <= FIELD_OFF_RST;
    end else if (ce && wr_off) begin
      field_off_threshold_r <= {1'b0, pwdata[6:0]};
    end
  end

  // ==========================================================
  // regulator control register
  // ==========================================================
  // rw register, resets to zero
  // read-only words ignore writes
  // reserved measure codes are kept; the valid flag marks them
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      regulator_voltage_control_r <= REG_CTRL_RST;
    end else if (ce && wr_ctrl) begin
      regulator_voltage_control_r <= pwdata[7:0];
    end
  end

  // ==========================================================
  // field detector control decode
  // ==========================================================
  wire [2:0] peer_nxt = field_off_threshold_r[PEER_LSB+:PEER_W];
  wire [3:0] coll_nxt = field_off_threshold_r[COLL_LSB+:COLL_W];
  // collision msb selects the low range
  // software must keep this bit equal in the activation twin
  wire coll_low_nxt = coll_nxt[COLL_W-1];

  // codes are re-registered so the detector sees clean edges
  // peer code to detector
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      peer_code_r <= 3'h0;
      coll_code_r <= 4'h0;
      coll_low_r <= 1'b0;
    end else if (ce) begin
      peer_code_r <= peer_nxt;
      coll_code_r <= coll_nxt;
      coll_low_r <= coll_low_nxt;
    end
  end

  // peer codes use the high range half of the table
  // peer code to millivolts
  thresh_mv_lut u_peer_mv (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .code({1'b0, peer_nxt}),
    .mv_r(peer_thresh_mv)
  );

  thresh_mv_lut u_coll_mv (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .code(coll_nxt),
    .mv_r(coll_thresh_mv)
  );

  assign peer_thresh_code = peer_code_r;
  assign coll_thresh_code = coll_code_r;
  assign coll_low_range = coll_low_r;

  // ==========================================================
  // regulator decode
  // ==========================================================
  // the adjust result is sampled first, so in adjust mode the code
  // follows it two cycles late; host mode follows one cycle late
  wire host_sel_nxt = regulator_voltage_control_r[HOST_SEL_BIT];
  wire [3:0] ext_code =
    regulator_voltage_control_r[EXT_CODE_LSB+:EXT_CODE_W];
  wire [2:0] meas_nxt = regulator_voltage_control_r[MEAS_LSB+:MEAS_W];
  wire [3:0] rf_code_nxt = host_sel_nxt ? ext_code : reg_sample[4:1];
  // 5v mode fixes 3.4v
  // in 3.3 v mode digital and analogue track the rf code
  wire [3:0] dig_ana_nxt = supply_5v_mode ? DIG_ANA_3V4_CODE : rf_code_nxt;
  wire meas_valid_nxt = (meas_nxt <= MEAS_AM);

  // regulator and measurement controls registered
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      host_sel_r <= 1'b0;
      rf_code_r <= 4'h0;
      dig_ana_code_r <= 4'h0;
      at_3v4_r <= 1'b0;
      meas_sel_r <= 3'h0;
      meas_valid_r <= 1'b0;
    end else if (ce) begin
      host_sel_r <= host_sel_nxt;
      rf_code_r <= rf_code_nxt;
      dig_ana_code_r <= dig_ana_nxt;
      at_3v4_r <= supply_5v_mode;
      meas_sel_r <= meas_nxt;
      meas_valid_r <= meas_valid_nxt;
    end
  end

  // regulator outputs are driven straight from their flops
  assign reg_from_host = host_sel_r;
  assign reg_rf_code = rf_code_r;
  assign reg_dig_ana_code = dig_ana_code_r;
  assign dig_ana_at_3v4 = at_3v4_r;
  assign supply_meas_sel = meas_sel_r;
  assign supply_meas_valid = meas_valid_r;

  // ==========================================================
  // driver timing decode
  // ==========================================================
  // top speed bit means fast
  // every 1xx code is fast, so only the top bit is needed
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      fast_r <= 1'b0;
    end else if (ce) begin
      fast_r <= drive_speed[SPEED_W-1];
    end
  end

  assign drive_is_fast = fast_r;

endmodule

// >>> rtl/fthr_pkg.sv
/*
 * constants for the field threshold and regulator register bank:
 * register indexes, field positions, reset values, threshold table.
 * assumes a 32-bit apb with byte addresses equal to four times the index.
 */
package fthr_pkg;

  // ==========================================================
  // register indexes (byte address is four times the index)
  // ==========================================================
  localparam logic [7:0] IDX_FIELD_OFF_THRESHOLD = 8'h2b;
  localparam logic [7:0] IDX_REGULATOR_VOLTAGE_CONTROL = 8'h2c;
  localparam logic [7:0] IDX_DRIVER_TIMING_READOUT = 8'h2b;
  localparam logic [7:0] IDX_REGULATOR_DISPLAY = 8'h2c;
  // second register space sits this many indexes above the first
  localparam logic [7:0] SPACE_B_BASE = 8'h40;

  // ==========================================================
  // field positions
  // ==========================================================
  localparam int PEER_LSB = 4;
  localparam int PEER_W = 3;
  localparam int COLL_LSB = 0;
  localparam int COLL_W = 4;
  localparam int RATIO_LSB = 4;
  localparam int RATIO_W = 4;
  localparam int SPEED_LSB = 0;
  localparam int SPEED_W = 3;
  localparam int HOST_SEL_BIT = 7;
  localparam int EXT_CODE_LSB = 3;
  localparam int EXT_CODE_W = 4;
  localparam int MEAS_LSB = 0;
  localparam int MEAS_W = 3;
  localparam int ADJ_LSB = 4;
  localparam int ILIM_BIT = 0;

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [7:0] FIELD_OFF_RST = 8'h33;
  localparam logic [7:0] REG_CTRL_RST = 8'h00;

  // ==========================================================
  // codes
  // ==========================================================
  localparam logic [2:0] MEAS_MAIN = 3'h0;
  localparam logic [2:0] MEAS_ANALOG = 3'h1;
  localparam logic [2:0] MEAS_DIGITAL = 3'h2;
  localparam logic [2:0] MEAS_RF = 3'h3;
  localparam logic [2:0] MEAS_AM = 3'h4;
  localparam logic [2:0] SPEED_SLOW = 3'h0;
  localparam logic [2:0] SPEED_MED_SLOW = 3'h1;
  localparam logic [2:0] SPEED_NOMINAL = 3'h2;
  localparam logic [2:0] SPEED_MED_FAST = 3'h3;
  // code giving 3.4 v in 3.3 v mode, used for the fixed 5 v case
  localparam logic [3:0] DIG_ANA_3V4_CODE = 4'hf;

  // threshold in mvpp per collision code; peer uses entries 0..7
  localparam int MV_W = 10;
  localparam logic [15:0][9:0] THRESH_MV_TABLE = {
    10'd250, 10'd175, 10'd125, 10'd90, 10'd64, 10'd47, 10'd33, 10'd25,
    10'd800, 10'd560, 10'd400, 10'd290, 10'd205, 10'd150, 10'd105, 10'd75
  };

  typedef enum logic [0:0] {
    APB_IDLE = 1'b0,
    APB_ANSWER = 1'b1
  } apb_state_t;

endpackage

// >>> rtl/readout_sample.sv
/*
 * samples a status word from the analogue side into a register.
 * assumes the word is synchronous to clk_sys.
 */
`timescale 1ns/10ps
module readout_sample #(
  parameter int W = 8
) (
  // clock and control
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  // status in, registered copy out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q_r
);
  // sample every enabled cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      q_r <= '0;
    end else if (ce) begin
      q_r <= d;
    end
  end
endmodule

// >>> rtl/thresh_mv_lut.sv
/*
 * converts a threshold code into millivolts peak to peak, registered.
 * assumes codes arrive synchronous to clk_sys.
 */
`timescale 1ns/10ps
module thresh_mv_lut (
  // clock and control
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  // code in, voltage out
  input wire logic [3:0] code,
  output logic [fthr_pkg::MV_W-1:0] mv_r
);
  import fthr_pkg::*;

  wire [MV_W-1:0] mv_nxt = THRESH_MV_TABLE[code];

  // table value taken into a register
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mv_r <= 10'h000;
    end else if (ce) begin
      mv_r <= mv_nxt;
    end
  end
endmodule

// >>> tb/field_threshold_regulator_regs_monitor.sv
/*
 * assertion checker for the threshold and regulator register bank.
 * assumes it is bound to field_threshold_regulator_regs by the bind below.
 */
`timescale 1ns/10ps
module field_threshold_regulator_regs_monitor #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  // apb
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // status and controls
  input wire logic [3:0] adj_result,
  input wire logic [2:0] peer_thresh_code,
  input wire logic [3:0] coll_thresh_code,
  input wire logic coll_low_range,
  input wire logic reg_from_host,
  input wire logic [3:0] reg_rf_code,
  input wire logic [3:0] reg_dig_ana_code,
  input wire logic dig_ana_at_3v4,
  input wire logic [2:0] supply_meas_sel,
  input wire logic supply_meas_valid
);
  // ==========================================================
  // clocking and sequences
  // ==========================================================
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // last cycle of a write transfer to one address
  sequence wr_end(logic [ADDR_W-1:0] a);
    pready && pwrite && pstrb[0] && ce && paddr == a;
  endsequence

  // ==========================================================
  // assertions
  // ==========================================================
  pready_pulse_a: assert property (pready && ce |=> !pready && prdata == 0)
    else $error("pready or read data held past the transfer");
  map_err_a: assert property (pready |-> pslverr == !(paddr inside
    {12'h0ac, 12'h0b0, 12'h1ac, 12'h1b0}))
    else $error("error response wrong for address");
  thr_write_a: assert property (wr_end(12'h0ac) |-> ##2
    peer_thresh_code == $past(pwdata[6:4], 2) &&
    coll_thresh_code == $past(pwdata[3:0], 2))
    else $error("threshold codes do not follow write");
  ctrl_write_a: assert property (wr_end(12'h0b0) |-> ##2
    reg_from_host == $past(pwdata[7], 2) &&
    supply_meas_sel == $past(pwdata[2:0], 2))
    else $error("regulator control does not follow write");
  host_code_a: assert property (wr_end(12'h0b0) ##0 pwdata[7]
    |-> ##2 reg_rf_code == $past(pwdata[6:3], 2))
    else $error("host regulator code not applied");
  adj_follow_a: assert property ((ce && !reg_from_host) [*3]
    |-> reg_rf_code == $past(adj_result, 2))
    else $error("regulator code not following adjust result");
  dig_ana_a: assert property (reg_dig_ana_code ==
    (dig_ana_at_3v4 ? 4'hf : reg_rf_code))
    else $error("digital and analogue regulator code wrong");
  meas_valid_a: assert property ($past(resetn) |->
    supply_meas_valid == (supply_meas_sel <= 3'h4))
    else $error("measure select valid flag wrong");
  low_range_a: assert property (coll_low_range == coll_thresh_code[3])
    else $error("low range flag differs from code");
  ro_ignore_a: assert property (wr_end(12'h1ac) |=> ##1
    $stable(peer_thresh_code) && $stable(coll_thresh_code))
    else $error("readout write disturbed thresholds");
endmodule

bind field_threshold_regulator_regs field_threshold_regulator_regs_monitor
  #(.ADDR_W(ADDR_W)) u_mon (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .adj_result(adj_result), .peer_thresh_code(peer_thresh_code),
  .coll_thresh_code(coll_thresh_code), .coll_low_range(coll_low_range),
  .reg_from_host(reg_from_host), .reg_rf_code(reg_rf_code),
  .reg_dig_ana_code(reg_dig_ana_code), .dig_ana_at_3v4(dig_ana_at_3v4),
  .supply_meas_sel(supply_meas_sel), .supply_meas_valid(supply_meas_valid));

// >>> tb/test_field_threshold_regulator_regs.sv
/*
 * self-checking bench for the threshold and regulator register bank.
 * assumes the package, design and checker are compiled before it.
 */
`timescale 1ns/10ps
module test_field_threshold_regulator_regs;
  import fthr_pkg::*;
  // ==========================================================
  // addresses, signals, instance
  // ==========================================================
  localparam logic [11:0] A_THR = {2'b00, IDX_FIELD_OFF_THRESHOLD, 2'b00};
  localparam logic [11:0] A_CTL =
    {2'b00, IDX_REGULATOR_VOLTAGE_CONTROL, 2'b00};
  localparam logic [11:0] A_TIM =
    {2'b00, IDX_DRIVER_TIMING_READOUT + SPACE_B_BASE, 2'b00};
  localparam logic [11:0] A_DSP =
    {2'b00, IDX_REGULATOR_DISPLAY + SPACE_B_BASE, 2'b00};
  logic clk_sys = 0, resetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf, adj_result = '0, transient_ratio = '0;
  logic [2:0] drive_speed = '0, peer_thresh_code, supply_meas_sel;
  logic supply_5v_mode = 0, rf_current_limit = 0, pready, pslverr, er;
  logic [3:0] coll_thresh_code, reg_rf_code, reg_dig_ana_code;
  logic [MV_W-1:0] peer_thresh_mv, coll_thresh_mv;
  logic coll_low_range, reg_from_host, dig_ana_at_3v4;
  logic supply_meas_valid, drive_is_fast;
  int failures = 0, check_count = 0, cycles = 0;

  field_threshold_regulator_regs u_field_threshold_regulator_regs (
    .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_5v_mode(supply_5v_mode), .adj_result(adj_result),
    .rf_current_limit(rf_current_limit),
    .transient_ratio(transient_ratio), .drive_speed(drive_speed),
    .peer_thresh_code(peer_thresh_code),
    .coll_thresh_code(coll_thresh_code), .coll_low_range(coll_low_range),
    .peer_thresh_mv(peer_thresh_mv), .coll_thresh_mv(coll_thresh_mv),
    .reg_from_host(reg_from_host), .reg_rf_code(reg_rf_code),
    .reg_dig_ana_code(reg_dig_ana_code), .dig_ana_at_3v4(dig_ana_at_3v4),
    .supply_meas_sel(supply_meas_sel),
    .supply_meas_valid(supply_meas_valid), .drive_is_fast(drive_is_fast));

  // ==========================================================
  // clock, timeout, helpers
  // ==========================================================
  // 25 mhz clock
  always #20 clk_sys = ~clk_sys;

  // cut a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 3000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // if pready never rises, only the cycle timeout ends this wait
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // threshold in mvpp for a collision code; peer codes use the high range half
  function automatic logic [31:0] exp_mv(input logic [3:0] c);
    logic [9:0] hi[8] = '{75, 105, 150, 205, 290, 400, 560, 800};
    logic [9:0] lo[8] = '{25, 33, 47, 64, 90, 125, 175, 250};
    exp_mv = c[3] ? lo[c[2:0]] : hi[c[2:0]];
  endfunction

  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    logic [31:0] v, r;
    logic [3:0] e;
    void'($urandom(32'h32a1));
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check("peer_mv_rst", peer_thresh_mv, 205);
    apb(0, A_THR, 0);
    check("thr_rst", rd, 32'h33);
    apb(0, A_CTL, 0);
    check("ctl_rst", rd, 0);
    // every collision code, random peer code and stray bit 7
    // low-range bit is written only here; its twin lies outside
    for (int i = 0; i < 16; i++) begin
      v = $urandom();
      v[3:0] = i[3:0];
      apb(1, A_THR, v);
      apb(0, A_THR, 0);
      check("thr_rd", rd, {25'h0, v[6:0]});
      repeat (2) @(posedge clk_sys);
      check("peer_mv", peer_thresh_mv, exp_mv({1'b0, v[6:4]}));
      check("coll_mv", coll_thresh_mv, exp_mv(v[3:0]));
    end
    // byte strobe low, readout write, bad addresses: no change
    pstrb <= 4'he;
    apb(1, A_THR, 32'h0);
    pstrb <= 4'hf;
    apb(1, A_TIM, 32'hff);
    check("ro_wr_err", er, 0);
    apb(1, 12'h0b4, 32'h0);
    check("unmapped_err", er, 1);
    apb(0, A_THR + 12'h1, 0);
    check("unaligned_err", er, 1);
    apb(0, A_THR, 0);
    check("thr_kept", rd, {25'h0, v[6:0]});
    // readouts and regulator control with random analogue status
    for (int k = 0; k < 16; k++) begin
      r = $urandom();
      v = $urandom();
      v[7] = k[3];
      v[2:0] = k[2:0];
      transient_ratio <= r[7:4];
      adj_result <= r[11:8];
      rf_current_limit <= r[12];
      supply_5v_mode <= r[13];
      drive_speed <= k[2:0];
      apb(1, A_CTL, v);
      apb(0, A_CTL, 0);
      check("ctl_rd", rd, v[7:0]);
      apb(0, A_TIM, 0);
      check("timing_rd", rd, {r[7:4], 1'b0, k[2:0]});
      check("fast", drive_is_fast, k[2]);
      apb(0, A_DSP, 0);
      check("display_rd", rd, {r[11:8], 3'b000, r[12]});
      check("host_sel", reg_from_host, v[7]);
      e = v[7] ? v[6:3] : r[11:8];
      check("rf_code", reg_rf_code, e);
      check("dig_ana", reg_dig_ana_code, r[13] ? 4'hf : e);
      check("at_3v4", dig_ana_at_3v4, r[13]);
      check("meas_sel", supply_meas_sel, v[2:0]);
      check("meas_ok", supply_meas_valid, v[2:0] <= 3'h4);
    end
    // clock enable low freezes the fast decode, high lets it and the timing readout follow
    drive_speed <= 3'h4;
    repeat (2) @(posedge clk_sys);
    ce <= 1'b0;
    drive_speed <= 3'h0;
    repeat (4) @(posedge clk_sys);
    check("fast_frozen", drive_is_fast, 1'b1);
    ce <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check("fast_follow", drive_is_fast, 1'b0);
    apb(0, A_TIM, 0);
    check("timing_after_ce", rd[2:0], 3'h0);
    print_verdict();
  end
endmodule
